/* File: dv/iox_i2c_master.sv */
// iox_i2c_master: behavioural serial-bus host for the port expander bench
module iox_i2c_master (
	input wire logic pclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// set by the bench to add a one-cycle scl spike in each low phase
	logic glitch = 1'b0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// sda moves only while scl is low, except for start and stop
	task automatic start();
		sda_low <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda_low <= 1'b1;
		tk(4);
		scl <= 1'b0;
		tk(2);
	endtask
	// one bit in 8 cycles, 320 ns; a released line reads high
	// scl low 5, high 3: the slave's late sda release settles before the rise
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		tk(1);
		scl <= glitch;
		tk(1);
		scl <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(2);
		r = sda;
		tk(1);
		scl <= 1'b0;
		tk(1);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~more, r);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tk(1);
		scl <= 1'b1;
		tk(2);
		sda_low <= 1'b0;
		tk(4);
	endtask
endmodule

/* File: dv/iox_top_tb.sv */
// iox_top_tb: self-checking bench for the serial-bus port expander
module iox_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import iox_pkg::*;
	logic pclk = 1'b0;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic reset_in_n;
	logic addr_sel;
	logic [15:0] pin_i;
	logic [31:0] prdata;
	logic pready, pslverr, irq, sda_o, sda_oe, alert_o, alert_oe;
	logic [15:0] pin_o, pin_oe;
	logic scl, m_low, e, ack;
	logic [31:0] r;
	logic [7:0] v;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	// open-drain sda with pull-up
	wire sda_w = ~(m_low | (sda_oe & ~sda_o));
	localparam logic [7:0] R_PTR [8] = '{8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h07, 8'h00, 8'h01};
	// input rows: 16'h1234 seen through polarity 16'hf00f
	localparam logic [7:0] R_VAL [8] = '{8'h55, 8'ha5, 8'h0f, 8'hf0,
		8'h00, 8'h3c, 8'h3b, 8'he2};
	iox_top #(.FILT_CYC(2)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .reset_in_n(reset_in_n),
		.addr_sel(addr_sel), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .alert_o(alert_o), .alert_oe(alert_oe));
	iox_i2c_master m (.pclk(pclk), .sda(sda_w), .scl(scl),
		.sda_low(m_low));
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) fails++;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p,
		input logic [7:0] d);
		logic k1, k2, k3;
		m.start();
		m.wbyte({a, 1'b0}, k1);
		m.wbyte(p, k2);
		m.wbyte(d, k3);
		m.stop();
		ack = k1 & k2 & k3;
	endtask
	task automatic rd(input logic [7:0] p);
		logic k;
		m.start();
		m.wbyte({SLV_ADDR, 1'b0}, k);
		m.wbyte(p, k);
		m.start();
		m.wbyte({SLV_ADDR, 1'b1}, k);
		m.rbyte(1'b0, v);
		m.stop();
	endtask
	initial begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		reset_in_n <= 1'b1;
		addr_sel <= 1'b0;
		pin_i <= 16'h1234;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		m.tk(4);
		chk("pin_oe", pin_oe, 0);
		chk("pin_o", pin_o, 16'hffff);
		chk("alert_oe", alert_oe, 0);
		chk("alert_o", alert_o, 0);
		chk("sda_o", sda_o, 0);
		chk("pready", pready, 0);
		for (int i = 0; i < 8; i++) begin
			if (R_PTR[i] > 8'h01) wr(SLV_ADDR, R_PTR[i], R_VAL[i]);
			rd(R_PTR[i]);
			chk("readback", v, R_VAL[i]);
		end
		chk("pin_o", pin_o, 16'ha555);
		chk("pin_oe", pin_oe, 16'hc3ff);
		apb(1'b1, A_DIR, 32'hffffffff);
		apb(1'b0, A_DIR, 0);
		chk("dir_reg", r, 32'ha5553c00);
		apb(1'b0, 8'h10, 0);
		chk("pslverr", e, 1);
		apb(1'b0, A_STAT, 0);
		chk("status", r, 32'h7);
		apb(1'b1, A_STAT, 32'h7);
		apb(1'b1, A_MASK, 32'h1);
		chk("irq", irq, 0);
		pin_i <= 16'h1634;
		m.tk(10);
		chk("alert_oe", alert_oe, 1);
		chk("irq", irq, 1);
		rd(8'h01);
		chk("port1", v, 8'he6);
		m.tk(4);
		chk("alert_oe", alert_oe, 0);
		apb(1'b1, A_STAT, 32'h1);
		chk("irq", irq, 0);
		apb(1'b1, A_MASK, 0);
		pin_i <= 16'h1234;
		m.tk(10);
		chk("alert_oe", alert_oe, 1);
		chk("irq", irq, 0);
		m.glitch = 1'b1;
		wr(SLV_ADDR, 8'h02, 8'h99);
		m.glitch = 1'b0;
		chk("pin_o", {ack, pin_o[7:0]}, 9'h199);
		wr(7'h21, 8'h02, 8'h66);
		chk("ack", ack, 0);
		addr_sel <= 1'b1;
		m.tk(4);
		wr(7'h21, 8'h02, 8'h66);
		chk("pin_o", {ack, pin_o[7:0]}, 9'h166);
		reset_in_n <= 1'b0;
		m.tk(5);
		reset_in_n <= 1'b1;
		m.tk(6);
		chk("pin_oe", pin_oe, 0);
		chk("pin_o", pin_o, 16'hffff);
		apb(1'b0, A_STAT, 0);
		chk("status", r[0], 1);
		presetn <= 1'b0;
		m.tk(2);
		presetn <= 1'b1;
		m.tk(4);
		apb(1'b0, A_STAT, 0);
		chk("status", r, 0);
		end_sim();
	end
endmodule

/* File: hw/iox_top.sv */
// iox_top: serial-bus 16-pin port expander with apb interrupt registers
//
// The APB slave port and the placing of the registers were decided locally.
module iox_top #(
	parameter int FILT_CYC = iox_pkg::FILT_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic reset_in_n,
	input wire logic addr_sel,
	input wire logic [iox_pkg::PINS-1:0] pin_i,
	output logic [iox_pkg::PINS-1:0] pin_o,
	output logic [iox_pkg::PINS-1:0] pin_oe,
	output logic alert_o,
	output logic alert_oe
);
	import iox_pkg::*;

	if (FILT_CYC < 1 || FILT_CYC > 8) begin : g_chk
		$error("FILT_CYC must lie in 1..8");
	end

	localparam logic [2:0] FC1 = 3'(FILT_CYC - 1);

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] rst_s;
		logic [1:0] asel_s;
		logic [1:0][15:0] pin_s;
		logic scl_f;
		logic sda_f;
		logic [2:0] sclc;
		logic [2:0] sdac;
		logic [15:0] inreg;
		logic [15:0] outreg;
		logic [15:0] pol;
		logic [15:0] cfg;
		logic [1:0] init;
		iox_st_t st;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [2:0] ptr;
		logic rw;
		logic first;
		logic nack;
		logic sda_oe;
		logic alert_oe;
		logic [EV_N-1:0] stat;
		logic [EV_N-1:0] mask;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [15:0] pin_o;
		logic [15:0] pin_oe;
	} iox_state_t;

	localparam iox_state_t RST_S = '{
		scl_s: 2'h3, sda_s: 2'h3, rst_s: 2'h3, asel_s: 2'h0,
		pin_s: '0, scl_f: 1'b1, sda_f: 1'b1, sclc: 3'h0, sdac: 3'h0,
		inreg: 16'h0000, outreg: RST_OUT, pol: RST_POL, cfg: RST_CFG,
		init: 2'h3, st: S_IDLE, bitc: 4'h0, sh: 8'h00, ptr: 3'h0,
		rw: 1'b0, first: 1'b0, nack: 1'b0, sda_oe: 1'b0,
		alert_oe: 1'b0, stat: '0, mask: '0, irq: 1'b0,
		prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
		pin_o: RST_OUT, pin_oe: ~RST_CFG
	};

	iox_state_t s_q;
	iox_state_t s_d;
	logic scl_r;
	logic scl_fl;
	logic start;
	logic stop;
	logic ld;
	logic wr_ev;
	logic rd_ev;
	logic addr_hit;
	logic apb_acc;
	logic [15:0] live;
	logic [15:0] diff_q;
	logic [7:0] rdb;
	logic [EV_N-1:0] ev;
	logic [EV_N-1:0] clr;

	// keep a level until it has differed for FILT_CYC samples
	function automatic logic [3:0] filt(input logic raw, input logic f,
			input logic [2:0] c);
		if (raw == f) begin
			filt = {f, 3'h0};
		end else if (c == FC1) begin
			filt = {raw, 3'h0};
		end else begin
			filt = {f, 3'(c + 3'h1)};
		end
	endfunction

	function automatic logic [7:0] rd_sel(input logic [2:0] p,
			input iox_state_t s, input logic [15:0] lv);
		logic [15:0] w;
		w = 16'h0000;
		unique case (p[2:1])
			G_IN: w = lv;
			G_OUT: w = s.outreg;
			G_POL: w = s.pol;
			G_CFG: w = s.cfg;
		endcase
		rd_sel = w[{p[0], 3'b000} +: 8];
	endfunction

	// pointer steps between the two ports of one group
	function automatic logic [2:0] inc(input logic [2:0] p);
		inc = {p[2:1], ~p[0]};
	endfunction

	assign live = s_q.pin_s[1] ^ s_q.pol;
	assign diff_q = (live ^ s_q.inreg) & s_q.cfg & {16{~|s_q.init}};

	always_comb begin
		s_d = s_q;
		scl_r = 1'b0;
		scl_fl = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		ld = 1'b0;
		wr_ev = 1'b0;
		rd_ev = 1'b0;
		addr_hit = 1'b0;
		rdb = rd_sel(s_q.ptr, s_q, live);
		s_d.scl_s = {s_q.scl_s[0], scl_i};
		s_d.sda_s = {s_q.sda_s[0], sda_i};
		s_d.rst_s = {s_q.rst_s[0], reset_in_n};
		s_d.asel_s = {s_q.asel_s[0], addr_sel};
		s_d.pin_s = {s_q.pin_s[0], pin_i};
		{s_d.scl_f, s_d.sclc} = filt(s_q.scl_s[1], s_q.scl_f, s_q.sclc);
		{s_d.sda_f, s_d.sdac} = filt(s_q.sda_s[1], s_q.sda_f, s_q.sdac);
		scl_r = ~s_q.scl_f & s_d.scl_f;
		scl_fl = s_q.scl_f & ~s_d.scl_f;
		start = s_q.scl_f & s_d.scl_f & s_q.sda_f & ~s_d.sda_f;
		stop = s_q.scl_f & s_d.scl_f & ~s_q.sda_f & s_d.sda_f;
		if (!s_q.rst_s[1]) begin
			// reset pin: port registers, pointer and bus machine as at power-on; apb status and mask kept
			s_d.outreg = RST_OUT;
			s_d.pol = RST_POL;
			s_d.cfg = RST_CFG;
			s_d.init = 2'h3;
			s_d.st = S_IDLE;
			s_d.sda_oe = 1'b0;
			s_d.bitc = 4'h0;
			s_d.ptr = 3'h0;
		end else if (s_q.init != 2'h0) begin
			// capture once the pin synchroniser has refilled after reset
			s_d.inreg = live;
			s_d.init = s_q.init - 2'h1;
		end else if (stop) begin
			s_d.st = S_IDLE;
			s_d.sda_oe = 1'b0;
		end else if (start) begin
			s_d.st = S_ADDR;
			s_d.bitc = 4'h0;
			s_d.first = 1'b1;
			s_d.sda_oe = 1'b0;
		end else begin
			unique case (s_q.st)
				S_IDLE: begin
				end
				S_ADDR, S_WR: begin
					if (scl_r) begin
						s_d.sh = {s_q.sh[6:0], s_q.sda_f};
						s_d.bitc = s_q.bitc + 4'h1;
					end
					if (scl_fl && s_q.bitc == 4'h8) begin
						s_d.bitc = 4'h0;
						if (s_q.st == S_ADDR) begin
							if (s_q.sh[7:1] ==
									{SLV_ADDR[6:1], s_q.asel_s[1]}) begin
								addr_hit = 1'b1;
								s_d.rw = s_q.sh[0];
								s_d.sda_oe = 1'b1;
								s_d.st = S_AACK;
							end else begin
								s_d.st = S_IDLE;
							end
						end else begin
							s_d.sda_oe = 1'b1;
							s_d.st = S_WACK;
							if (s_q.first) begin
								s_d.ptr = s_q.sh[2:0];
								s_d.first = 1'b0;
							end else begin
								wr_ev = 1'b1;
								s_d.ptr = inc(s_q.ptr);
								// input group is read-only
								unique case (s_q.ptr[2:1])
									G_IN: begin
									end
									G_OUT: s_d.outreg[{s_q.ptr[0], 3'b000} +: 8] =
										s_q.sh;
									G_POL: s_d.pol[{s_q.ptr[0], 3'b000} +: 8] =
										s_q.sh;
									G_CFG: s_d.cfg[{s_q.ptr[0], 3'b000} +: 8] =
										s_q.sh;
								endcase
							end
						end
					end
				end
				S_WACK: begin
					if (scl_fl) begin
						s_d.sda_oe = 1'b0;
						s_d.st = S_WR;
					end
				end
				S_AACK, S_RACK: begin
					if (scl_r && s_q.st == S_RACK) begin
						s_d.nack = s_q.sda_f;
					end
					if (scl_fl) begin
						s_d.sda_oe = 1'b0;
						s_d.bitc = 4'h0;
						if (s_q.st == S_AACK && !s_q.rw) begin
							s_d.st = S_WR;
						end else if (s_q.st == S_RACK && s_q.nack) begin
							s_d.st = S_IDLE;
						end else begin
							// load a byte and put its msb on the line
							ld = 1'b1;
							rd_ev = 1'b1;
							s_d.st = S_RD;
							s_d.sh = rdb;
							s_d.sda_oe = ~rdb[7];
							s_d.bitc = 4'h1;
							s_d.ptr = inc(s_q.ptr);
							if (s_q.ptr[2:1] == G_IN) begin
								s_d.inreg[{s_q.ptr[0], 3'b000} +: 8] = rdb;
							end
						end
					end
				end
				S_RD: begin
					if (scl_fl) begin
						if (s_q.bitc == 4'h8) begin
							s_d.sda_oe = 1'b0;
							s_d.nack = 1'b0;
							s_d.st = S_RACK;
						end else begin
							s_d.sh = {s_q.sh[6:0], 1'b0};
							s_d.sda_oe = ~s_q.sh[6];
							s_d.bitc = s_q.bitc + 4'h1;
						end
					end
				end
				default: s_d.st = S_IDLE;
			endcase
		end
		s_d.alert_oe = |diff_q;
		s_d.pin_o = s_d.outreg;
		s_d.pin_oe = ~s_d.cfg;
		// apb slave: one wait cycle, then pready
		apb_acc = psel & penable & ~s_q.pready;
		s_d.pready = apb_acc;
		s_d.pslverr = 1'b0;
		clr = '0;
		if (apb_acc) begin
			s_d.prdata = 32'h0000_0000;
			unique case (paddr)
				A_STAT: begin
					if (pwrite) begin
						clr = pwdata[EV_N-1:0];
					end else begin
						s_d.prdata[EV_N-1:0] = s_q.stat;
					end
				end
				A_MASK: begin
					if (pwrite) begin
						s_d.mask = pwdata[EV_N-1:0];
					end else begin
						s_d.prdata[EV_N-1:0] = s_q.mask;
					end
				end
				A_PINS: begin
					if (!pwrite) begin
						s_d.prdata = {s_q.pin_oe, s_q.pin_s[1]};
					end
				end
				A_DIR: begin
					if (!pwrite) begin
						s_d.prdata = {s_q.outreg, s_q.cfg};
					end
				end
				default: s_d.pslverr = 1'b1;
			endcase
		end
		ev = '0;
		ev[EV_CHG] = s_d.alert_oe & ~s_q.alert_oe;
		ev[EV_WR] = wr_ev;
		ev[EV_RD] = rd_ev;
		// a new event beats a clear in the same cycle
		s_d.stat = (s_q.stat & ~clr) | ev;
		s_d.irq = |(s_d.stat & s_d.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= RST_S;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign irq = s_q.irq;
	assign sda_o = 1'b0;
	assign sda_oe = s_q.sda_oe;
	assign pin_o = s_q.pin_o;
	assign pin_oe = s_q.pin_oe;
	assign alert_o = 1'b0;
	assign alert_oe = s_q.alert_oe;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_rst_inputs: assert property (!s_q.rst_s[1] |=> pin_oe == 16'h0000)
		else $error("pins not inputs after reset");
	a_rst_idle: assert property (!s_q.rst_s[1] |=> s_q.st == S_IDLE && !sda_oe)
		else $error("bus machine not idle after reset pin");
	a_dir_write: assert property (wr_ev && s_q.ptr == 3'h6 |=> pin_oe[7:0] == ~$past(s_q.sh))
		else $error("direction write not applied to pins");
	a_out_hold: assert property (!wr_ev && s_q.rst_s[1] |=> $stable(pin_o))
		else $error("output changed without a write");
	a_rd_byte: assert property (ld |=> s_q.sh == $past(rdb) && sda_oe == ~s_q.sh[7])
		else $error("read byte does not match register");
	a_alert_set: assert property (|diff_q |=> alert_oe)
		else $error("alert not asserted on input change");
	a_alert_rel: assert property (!(|diff_q) |=> !alert_oe)
		else $error("alert held with no difference");
	a_addr_ack: assert property (addr_hit |=> sda_oe && s_q.st == S_AACK ##1 sda_oe)
		else $error("matching address not acknowledged");
	a_glitch_filt: assert property ($changed(s_q.scl_f) |-> $past(s_q.scl_s[1]) == s_q.scl_f && $past(s_q.scl_s[1], 2) == s_q.scl_f)
		else $error("clock line changed on a short pulse");
	a_stat_w1c: assert property (s_q.stat[EV_CHG] && !(apb_acc && pwrite && paddr == A_STAT && pwdata[EV_CHG]) |=> s_q.stat[EV_CHG])
		else $error("sticky status bit lost");
	c_wr_byte: cover property (wr_ev);
	c_rd_byte: cover property (ld ##[1:400] ld);
	c_irq: cover property ($rose(irq));
endmodule

/* File: include/iox_pkg.sv */
// iox_pkg: constants and types of the 16-pin serial-bus port expander
package iox_pkg;
	localparam int PINS = 16;
	// bits 6:1 fixed, bit 0 taken from the address-select pin
	localparam logic [6:0] SLV_ADDR = 7'h20;
	// register pointer: bits 2:1 pick the group, bit 0 the 8-bit port
	localparam logic [1:0] G_IN = 2'h0;
	localparam logic [1:0] G_OUT = 2'h1;
	localparam logic [1:0] G_POL = 2'h2;
	localparam logic [1:0] G_CFG = 2'h3;
	localparam logic [15:0] RST_OUT = 16'hffff;
	localparam logic [15:0] RST_POL = 16'h0000;
	localparam logic [15:0] RST_CFG = 16'hffff;
	// noise filter on the serial lines
	localparam int CLK_NS = 40;
	localparam int FILT_NS = 50;
	localparam int FILT_CYC_DEF = (FILT_NS + CLK_NS - 1) / CLK_NS;
	// apb byte offsets
	localparam logic [7:0] A_STAT = 8'h00;
	localparam logic [7:0] A_MASK = 8'h04;
	localparam logic [7:0] A_PINS = 8'h08;
	localparam logic [7:0] A_DIR = 8'h0c;
	// interrupt status bits
	localparam int EV_N = 3;
	localparam int EV_CHG = 0;
	localparam int EV_WR = 1;
	localparam int EV_RD = 2;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_AACK = 3'b010,
		S_WR = 3'b011,
		S_WACK = 3'b100,
		S_RD = 3'b101,
		S_RACK = 3'b110
	} iox_st_t;
endpackage
